// ===== rtl/pwm_output_routing.sv
// Purpose: pin routing, time base and waveforms for sixteen pulse outputs
// Assumes: peripheral clock equals core clock; AHB-Lite single word access
// Notes: pins are registered, so they follow a register by one more edge
`timescale 1ns/10ps
module pwm_output_routing (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	// hardware standby pin, asynchronous
	input wire logic standby_i,
	// ahb-lite slave
	input wire logic hsel_i,
	input wire logic [pwm_route_pkg::HADDR_W-1:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic hreadyout_o,
	output logic hresp_o,
	output logic [31:0] hrdata_o,
	// pulse output pins
	output logic [pwm_route_pkg::CHANNELS-1:0] pulse_outputs_o,
	output logic [pwm_route_pkg::CHANNELS-1:0] pulse_outputs_oe_n_o,
	// sideband to neighbouring units
	output logic [2:0] twowire_mode_o,
	output logic timer_link_out_enable_o,
	output logic [1:0] eight_bit_timer_clk_sel_o
);
	import pwm_route_pkg::*;

	logic [7:0] duty_value_r [CHANNELS];
	logic [15:0] polarity_control_r;
	logic [15:0] pulse_enable_r;
	logic [15:0] port_direction_r;
	logic [15:0] port_level_r;
	logic [7:0] serial_timer_control_r;
	logic [7:0] time_base_counter_r;
	logic half_div_r;
	logic [15:0] wave;
	logic tick;
	logic sb_s1_r, sb_s2_r, sb_s3_r, standby_r;
	logic wr_pend_r;
	logic [IDX_W-1:0] wr_idx_r;
	logic [IDX_W-1:0] addr_idx;
	logic addr_take;
	logic [31:0] rdata_nxt;
	logic [3:0] wr_duty;

	// inverted, bit-reversed rank of a basic pulse in the extra-pulse order
	function automatic logic [3:0] extra_rank(input logic [3:0] k);
		logic [3:0] n;
		n = ~k;
		return {n[0], n[1], n[2], n[3]};
	endfunction : extra_rank

	// standby pin: three stages, level counted once stages two and three agree
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			sb_s1_r <= 1'b0;
			sb_s2_r <= 1'b0;
			sb_s3_r <= 1'b0;
			standby_r <= 1'b0;
		end else begin
			sb_s1_r <= standby_i;
			sb_s2_r <= sb_s1_r;
			sb_s3_r <= sb_s2_r;
			if (sb_s2_r == sb_s3_r) begin
				standby_r <= sb_s3_r;
			end
		end
	end

	// bus address phase
	assign addr_idx = haddr_i[HADDR_W-1:2];
	assign addr_take = hsel_i && hready_i && htrans_i[1];
	assign wr_duty = wr_idx_r[3:0];

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			wr_pend_r <= 1'b0;
			wr_idx_r <= '0;
		end else begin
			wr_pend_r <= addr_take && hwrite_i;
			if (addr_take) begin
				wr_idx_r <= addr_idx;
			end
		end
	end

	// read data prepared in the address phase, so no wait states
	always_comb begin
		rdata_nxt = RDATA_NONE;
		if (addr_idx[IDX_W-1:4] == IDX_DUTY_BASE[IDX_W-1:4]) begin
			rdata_nxt[7:0] = duty_value_r[addr_idx[3:0]];
		end else begin
			case (addr_idx)
				IDX_POL_LOW: rdata_nxt[7:0] = polarity_control_r[7:0];
				IDX_POL_HIGH: rdata_nxt[7:0] = polarity_control_r[15:8];
				IDX_EN_LOW: rdata_nxt[7:0] = pulse_enable_r[7:0];
				IDX_EN_HIGH: rdata_nxt[7:0] = pulse_enable_r[15:8];
				IDX_LVL_ONE: rdata_nxt[7:0] = port_level_r[7:0];
				IDX_LVL_TWO: rdata_nxt[7:0] = port_level_r[15:8];
				IDX_CTL: rdata_nxt[7:0] = serial_timer_control_r;
				IDX_STATUS: rdata_nxt[7:0] = time_base_counter_r;
				// direction registers read as zero
				default: rdata_nxt = RDATA_NONE;
			endcase
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			hrdata_o <= RDATA_NONE;
			hreadyout_o <= 1'b1;
			hresp_o <= 1'b0;
		end else begin
			hreadyout_o <= 1'b1;
			hresp_o <= 1'b0;
			if (addr_take && !hwrite_i) begin
				hrdata_o <= rdata_nxt;
			end
		end
	end

	// duty and polarity registers
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i || standby_r) begin
			for (int i = 0; i < CHANNELS; i++) begin
				duty_value_r[i] <= RST_BYTE;
			end
			polarity_control_r <= {RST_BYTE, RST_BYTE};
		end else if (wr_pend_r) begin
			if (wr_idx_r[IDX_W-1:4] == IDX_DUTY_BASE[IDX_W-1:4]) begin
				duty_value_r[wr_duty] <= hwdata_i[7:0];
			end
			if (wr_idx_r == IDX_POL_LOW) begin
				polarity_control_r[7:0] <= hwdata_i[7:0];
			end
			if (wr_idx_r == IDX_POL_HIGH) begin
				polarity_control_r[15:8] <= hwdata_i[7:0];
			end
		end
	end

	// enable registers: cleared in standby too
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i || standby_r) begin
			pulse_enable_r <= {RST_BYTE, RST_BYTE};
		end else if (wr_pend_r) begin
			if (wr_idx_r == IDX_EN_LOW) begin
				pulse_enable_r[7:0] <= hwdata_i[7:0];
			end
			if (wr_idx_r == IDX_EN_HIGH) begin
				pulse_enable_r[15:8] <= hwdata_i[7:0];
			end
		end
	end

	// port direction and level; ports keep state across standby
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			port_direction_r <= {RST_BYTE, RST_BYTE};
			port_level_r <= {RST_BYTE, RST_BYTE};
		end else if (wr_pend_r) begin
			if (wr_idx_r == IDX_DIR_ONE) begin
				port_direction_r[7:0] <= hwdata_i[7:0];
			end
			if (wr_idx_r == IDX_DIR_TWO) begin
				port_direction_r[15:8] <= hwdata_i[7:0];
			end
			if (wr_idx_r == IDX_LVL_ONE) begin
				port_level_r[7:0] <= hwdata_i[7:0];
			end
			if (wr_idx_r == IDX_LVL_TWO) begin
				port_level_r[15:8] <= hwdata_i[7:0];
			end
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			serial_timer_control_r <= RST_BYTE;
		end else if (wr_pend_r && wr_idx_r == IDX_CTL) begin
			serial_timer_control_r <= hwdata_i[7:0];
		end
	end

	// sideband fields are only stored here
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			twowire_mode_o <= '0;
			timer_link_out_enable_o <= 1'b0;
			eight_bit_timer_clk_sel_o <= '0;
		end else begin
			twowire_mode_o <= serial_timer_control_r[CTL_TWOWIRE_LSB +: 3];
			timer_link_out_enable_o <= serial_timer_control_r[CTL_LINK_EN];
			eight_bit_timer_clk_sel_o <=
				serial_timer_control_r[CTL_TMR_SEL_LSB +: 2];
		end
	end

	// peripheral clock halved by a free-running enable
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			half_div_r <= 1'b0;
		end else begin
			half_div_r <= ~half_div_r;
		end
	end

	assign tick = serial_timer_control_r[CTL_CLK_ON] &&
		(!serial_timer_control_r[CTL_CLK_CHOICE] || half_div_r);

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			time_base_counter_r <= RST_BYTE;
		end else if (tick) begin
			time_base_counter_r <= time_base_counter_r + 8'h01;
		end
	end

	// upper counter nibble numbers the basic pulse, lower is its phase;
	// basic pulse rises late so that it ends at the pulse boundary
	always_comb begin
		logic [3:0] num, ph, hi, lo;
		logic basic, extra;
		num = time_base_counter_r[7:4];
		ph = time_base_counter_r[3:0];
		hi = '0;
		lo = '0;
		basic = 1'b0;
		extra = 1'b0;
		wave = '0;
		for (int c = 0; c < CHANNELS; c++) begin
			hi = duty_value_r[c][7:4];
			lo = duty_value_r[c][3:0];
			basic = ({1'b0, ph} >= (5'd16 - {1'b0, hi}));
			extra = (ph == (PHASE_LAST - hi)) && (extra_rank(num) < lo);
			wave[c] = (basic || extra) ^ polarity_control_r[c];
		end
	end

	// pin routing: direction gates the driver, enable picks the source
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			pulse_outputs_o <= '0;
			pulse_outputs_oe_n_o <= '1;
		end else begin
			pulse_outputs_oe_n_o <= ~port_direction_r;
			pulse_outputs_o <= port_direction_r &
				((pulse_enable_r & wave) | (~pulse_enable_r & port_level_r));
		end
	end

	// checks
	sequence s_ctl_wr;
		wr_pend_r && wr_idx_r == IDX_CTL;
	endsequence

	sequence s_en_low_wr;
		wr_pend_r && wr_idx_r == IDX_EN_LOW && !standby_r;
	endsequence

	sequence s_dir_two_wr;
		wr_pend_r && wr_idx_r == IDX_DIR_TWO;
	endsequence

	// software may change the rate at any edge, so judge settled pairs only
	sequence s_half_sel;
		serial_timer_control_r[CTL_CLK_ON] &&
		serial_timer_control_r[CTL_CLK_CHOICE];
	endsequence

	a_standby_clears_enable: assert property (@(posedge core_clk_i)
		disable iff (!rst_n_i) standby_r |=> pulse_enable_r == '0 &&
		duty_value_r[0] == RST_BYTE)
		else $error("enables or duty not cleared in standby");

	a_pin_drive_gate: assert property (@(posedge core_clk_i)
		disable iff (!rst_n_i) ##1
		pulse_outputs_oe_n_o == ~$past(port_direction_r))
		else $error("pin driven without direction bit");

	a_port_level_path: assert property (@(posedge core_clk_i)
		disable iff (!rst_n_i) ##1
		((pulse_outputs_o ^ $past(port_level_r)) &
		$past(port_direction_r & ~pulse_enable_r)) == '0)
		else $error("port level not routed to pin");

	a_wave_path: assert property (@(posedge core_clk_i)
		disable iff (!rst_n_i) ##1
		((pulse_outputs_o ^ $past(wave)) &
		$past(port_direction_r & pulse_enable_r)) == '0)
		else $error("waveform not routed to pin");

	a_clock_off_hold: assert property (@(posedge core_clk_i)
		disable iff (!rst_n_i) !serial_timer_control_r[CTL_CLK_ON] |=>
		time_base_counter_r == $past(time_base_counter_r))
		else $error("time base moved with clock off");

	a_half_rate_tick: assert property (@(posedge core_clk_i)
		disable iff (!rst_n_i) s_half_sel ##1 s_half_sel |->
		tick != $past(tick))
		else $error("halved clock not every other cycle");

	a_time_base_wrap: assert property (@(posedge core_clk_i)
		disable iff (!rst_n_i) (tick && time_base_counter_r == TB_LAST) |=>
		time_base_counter_r == RST_BYTE)
		else $error("time base did not wrap to zero");

	a_extra_slot: assert property (@(posedge core_clk_i)
		disable iff (!rst_n_i) (duty_value_r[0] == 8'h0f &&
		!polarity_control_r[0] && time_base_counter_r[3:0] == PHASE_LAST &&
		time_base_counter_r[7:4] != 4'h0) |-> wave[0])
		else $error("extra pulse missing before rising edge");

	a_ctl_write_side: assert property (@(posedge core_clk_i)
		disable iff (!rst_n_i) s_ctl_wr ##1 !wr_pend_r |=>
		twowire_mode_o == $past(hwdata_i[7:5], 2) &&
		eight_bit_timer_clk_sel_o == $past(hwdata_i[1:0], 2))
		else $error("control fields not passed on");

	a_enable_write_lands: assert property (@(posedge core_clk_i)
		disable iff (!rst_n_i) s_en_low_wr |=>
		pulse_enable_r[7:0] == $past(hwdata_i[7:0]))
		else $error("enable write did not land");

	a_direction_high_map: assert property (@(posedge core_clk_i)
		disable iff (!rst_n_i) s_dir_two_wr |=>
		port_direction_r[15:8] == $past(hwdata_i[7:0]))
		else $error("second port direction misplaced");

	a_link_enable_copy: assert property (@(posedge core_clk_i)
		disable iff (!rst_n_i) ##1 timer_link_out_enable_o ==
		$past(serial_timer_control_r[CTL_LINK_EN]))
		else $error("link enable not passed on");

	a_timer_sel_copy: assert property (@(posedge core_clk_i)
		disable iff (!rst_n_i) ##1 eight_bit_timer_clk_sel_o ==
		$past(serial_timer_control_r[CTL_TMR_SEL_LSB +: 2]))
		else $error("timer clock select not passed on");

	a_control_reset_clear: assert property (@(posedge core_clk_i)
		!rst_n_i |=> serial_timer_control_r == RST_BYTE)
		else $error("control register not cleared by reset");

	a_duty_reset_clear: assert property (@(posedge core_clk_i)
		(!rst_n_i || standby_r) |=>
		duty_value_r[CHANNELS-1] == RST_BYTE && polarity_control_r == '0)
		else $error("duty or polarity not cleared");

	a_counter_step: assert property (@(posedge core_clk_i)
		disable iff (!rst_n_i) tick |=>
		time_base_counter_r == $past(time_base_counter_r) + 8'h01)
		else $error("time base did not step on tick");

	a_basic_half_duty: assert property (@(posedge core_clk_i)
		disable iff (!rst_n_i) (duty_value_r[0] == 8'h80 &&
		!polarity_control_r[0]) |-> wave[0] == time_base_counter_r[3])
		else $error("half duty basic pulse misplaced");
endmodule : pwm_output_routing

// ===== rtl/pwm_route_pkg.sv
// Purpose: constants for the pulse output routing and clock select block
// Assumes: register index is the printed address, byte address = 4 * index
// Notes: data registers sit at sixteen consecutive indices from duty base
package pwm_route_pkg;
	localparam int CHANNELS = 16;
	localparam int HADDR_W = 18;
	localparam int IDX_W = 16;
	// register indices
	localparam logic [IDX_W-1:0] IDX_DUTY_BASE = 16'hfff0;
	localparam logic [IDX_W-1:0] IDX_POL_LOW = 16'hffcf;
	localparam logic [IDX_W-1:0] IDX_POL_HIGH = 16'hffce;
	localparam logic [IDX_W-1:0] IDX_EN_LOW = 16'hffd5;
	localparam logic [IDX_W-1:0] IDX_EN_HIGH = 16'hffcd;
	localparam logic [IDX_W-1:0] IDX_DIR_ONE = 16'hffb0;
	localparam logic [IDX_W-1:0] IDX_DIR_TWO = 16'hffb1;
	localparam logic [IDX_W-1:0] IDX_LVL_ONE = 16'hffb2;
	localparam logic [IDX_W-1:0] IDX_LVL_TWO = 16'hffb3;
	localparam logic [IDX_W-1:0] IDX_CTL = 16'hffc3;
	localparam logic [IDX_W-1:0] IDX_STATUS = 16'hffc0;
	// serial_timer_control fields
	localparam int CTL_TWOWIRE_LSB = 5;
	localparam int CTL_LINK_EN = 4;
	localparam int CTL_CLK_ON = 3;
	localparam int CTL_CLK_CHOICE = 2;
	localparam int CTL_TMR_SEL_LSB = 0;
	// reset values and time base end values
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [7:0] TB_LAST = 8'hff;
	localparam logic [3:0] PHASE_LAST = 4'hf;
	// ahb-lite
	localparam logic [1:0] HTRANS_IDLE = 2'b00;
	localparam logic [31:0] RDATA_NONE = 32'h0000_0000;
endpackage : pwm_route_pkg

// ===== dv/tb_top.sv
// Purpose: self-checking bench for pulse routing and counter clock select
// Assumes: zero-wait ahb-lite slave, pins registered one edge after regs
// Notes: high times are counted over whole 256-tick conversion periods
`timescale 1ns/10ps
module tb_top;
	import pwm_route_pkg::*;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic standby = 1'b0;
	logic hsel = 1'b0;
	logic [HADDR_W-1:0] haddr = '0;
	logic [1:0] htrans = HTRANS_IDLE;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = '0;
	logic hready;
	logic hresp;
	logic [31:0] hrdata;
	logic [CHANNELS-1:0] pins;
	logic [CHANNELS-1:0] pins_oe_n;
	logic [2:0] twowire;
	logic link_en;
	logic [1:0] tmr_sel;
	int num_errors = 0;
	int n_tests = 0;
	int cycles = 0;

	pwm_output_routing pwm_output_routing_i (
		.core_clk_i(core_clk),
		.rst_n_i(rst_n),
		.standby_i(standby),
		.hsel_i(hsel),
		.haddr_i(haddr),
		.htrans_i(htrans),
		.hwrite_i(hwrite),
		.hsize_i(3'h2),
		.hwdata_i(hwdata),
		.hready_i(hready),
		.hreadyout_o(hready),
		.hresp_o(hresp),
		.hrdata_o(hrdata),
		.pulse_outputs_o(pins),
		.pulse_outputs_oe_n_o(pins_oe_n),
		.twowire_mode_o(twowire),
		.timer_link_out_enable_o(link_en),
		.eight_bit_timer_clk_sel_o(tmr_sel)
	);

	initial begin
		forever #12.5 core_clk = ~core_clk;
	end

	// whole run needs about 4000 cycles
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			num_errors++;
			wrap_up();
		end
	end

	task automatic wrap_up;
		$display("errors %0d checks %0d", num_errors, n_tests);
		if (num_errors == 0 && n_tests > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : wrap_up

	task automatic chk(input string what, input logic [31:0] exp,
			input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// one single transfer; read data taken at the edge ending the data phase
	task automatic xfer(input logic [IDX_W-1:0] idx, input logic we,
			input logic [7:0] d, output logic [31:0] q);
		@(posedge core_clk);
		hsel <= 1'b1;
		haddr <= {idx, 2'b00};
		htrans <= 2'b10;
		hwrite <= we;
		@(posedge core_clk);
		while (hready !== 1'b1) @(posedge core_clk);
		htrans <= HTRANS_IDLE;
		hwdata <= {24'h0, d};
		@(posedge core_clk);
		while (hready !== 1'b1) @(posedge core_clk);
		q = hrdata;
		chk("hresp", 32'h0, {31'h0, hresp});
	endtask : xfer

	task automatic wr(input logic [IDX_W-1:0] idx, input logic [7:0] d);
		logic [31:0] q;
		xfer(idx, 1'b1, d, q);
	endtask : wr

	task automatic rd(input string what, input logic [IDX_W-1:0] idx,
			input logic [7:0] exp);
		logic [31:0] q;
		xfer(idx, 1'b0, 8'h00, q);
		chk(what, {24'h0, exp}, q);
	endtask : rd

	// pins follow the register one edge after the write lands
	task automatic settle;
		repeat (2) @(posedge core_clk);
		#1;
	endtask : settle

	// skip one window so a duty change can take hold first
	task automatic high_count(input int ncyc, input int exp);
		int n;
		n = 0;
		repeat (ncyc) @(posedge core_clk);
		repeat (ncyc) begin
			@(posedge core_clk);
			#1;
			n += int'(pins[0]);
		end
		chk("pulse0 high cycles", 32'(exp), 32'(n));
	endtask : high_count

	task automatic t_reset;
		chk("hready", 32'h1, {31'h0, hready});
		rd("enable low", IDX_EN_LOW, 8'h00);
		rd("enable high", IDX_EN_HIGH, 8'h00);
		rd("control", IDX_CTL, 8'h00);
		rd("direction one", IDX_DIR_ONE, 8'h00);
		chk("pins", 32'h0, {16'h0, pins});
		chk("pins oe_n", 32'hffff, {16'h0, pins_oe_n});
	endtask : t_reset

	task automatic t_clk_off;
		wr(IDX_CTL, 8'h04);
		repeat (300) @(posedge core_clk);
		rd("held time base", IDX_STATUS, 8'h00);
	endtask : t_clk_off

	task automatic t_sideband;
		wr(IDX_CTL, 8'he3);
		settle();
		chk("twowire", 32'h7, {29'h0, twowire});
		chk("link enable", 32'h0, {31'h0, link_en});
		chk("timer select", 32'h3, {30'h0, tmr_sel});
		wr(IDX_CTL, 8'h12);
		settle();
		chk("twowire", 32'h0, {29'h0, twowire});
		chk("link enable", 32'h1, {31'h0, link_en});
		chk("timer select", 32'h2, {30'h0, tmr_sel});
		rd("control", IDX_CTL, 8'h12);
	endtask : t_sideband

	task automatic t_route;
		wr(IDX_DIR_ONE, 8'h0f);
		wr(IDX_DIR_TWO, 8'h80);
		wr(IDX_LVL_ONE, 8'ha5);
		wr(IDX_LVL_TWO, 8'hff);
		wr(IDX_EN_LOW, 8'h30);
		wr(16'hff00, 8'h5a);
		settle();
		chk("pins", 32'h8005, {16'h0, pins});
		chk("pins oe_n", 32'h7ff0, {16'h0, pins_oe_n});
		rd("direction one", IDX_DIR_ONE, 8'h00);
		rd("enable low", IDX_EN_LOW, 8'h30);
		rd("unmapped", 16'hff00, 8'h00);
	endtask : t_route

	task automatic t_wave;
		wr(IDX_EN_LOW, 8'h01);
		wr(IDX_CTL, 8'h08);
		high_count(256, 0);
		wr(IDX_DUTY_BASE, 8'h80);
		high_count(256, 128);
		wr(IDX_DUTY_BASE, 8'h0f);
		high_count(256, 15);
		wr(IDX_DUTY_BASE, 8'h4b);
		high_count(256, 75);
		wr(IDX_POL_LOW, 8'h01);
		high_count(256, 181);
		wr(IDX_CTL, 8'h0c);
		high_count(512, 362);
	endtask : t_wave

	task automatic t_standby;
		@(posedge core_clk);
		standby <= 1'b1;
		repeat (8) @(posedge core_clk);
		#1;
		chk("pins low byte", 32'h05, {24'h0, pins[7:0]});
		rd("enable low", IDX_EN_LOW, 8'h00);
		rd("duty 0", IDX_DUTY_BASE, 8'h00);
		rd("level one", IDX_LVL_ONE, 8'ha5);
		@(posedge core_clk);
		standby <= 1'b0;
	endtask : t_standby

	initial begin
		repeat (6) @(posedge core_clk);
		rst_n <= 1'b1;
		t_reset();
		t_clk_off();
		t_sideband();
		t_route();
		t_wave();
		t_standby();
		wrap_up();
	end
endmodule : tb_top
